// ==== shared/ifetch_pkg.sv ====
/*
 * Shared constants and types for the instruction prefetch silo and the
 * microsequencer front end: cycle timing, widths, microword field layout,
 * reset values, carrier structs and state records.
 * Assumes a single 100 MHz processor clock and a synchronous reset.
 */
// Notes on behaviour
// RQ1: Silo holds up to eight prefetched stream bytes.
// RQ2: Silo requests bus read when room and bus free.
// RQ3: Decoded opcode goes to execution unit and accelerator.
// RQ4: Sequencer computes next micro-address normally.
// RQ5: New instruction start uses its microroutine entry point.
// RQ6: Partial-completion flag forces the resume micro-address.
// RQ7: Micro-address driven onto bus in first half.
// RQ8: Control store returns microword in second half.
// RQ9: Fresh microinstruction ready every 200 ns cycle.
// RQ10: Microinstruction words are 40 bits wide.
// RQ11: Flow change flushes silo and restarts prefetch.
// RQ12: Consumed bytes leave in order, count updated immediately.
package ifetch_pkg;
   // Processor cycle and clock period in nanoseconds.
   localparam int CYCLE_NS = 200;
   localparam int CLK_NS = 10;
   // Clocks per processor cycle and per half cycle.
   localparam int CYCLE_CLKS = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HALF_CLKS = CYCLE_CLKS / 2;
   // Silo depth in bytes and the width of one bus read in bytes.
   localparam int SILO_BYTES = 8;
   localparam int WORD_BYTES = 4;
   localparam int BUS_BITS = 32;
   // Microword and micro-address widths.
   localparam int UWORD_BITS = 40;
   localparam int UADDR_BITS = 14;
   // Microword fields: next address and the dispatch request bit.
   localparam int UI_NEXT_LSB = 0;
   localparam int UI_DISPATCH_BIT = 14;
   // Upper micro-address bits of the opcode entry point table.
   localparam logic [5:0] ENTRY_PAGE = 6'h00;
   // Reset values.
   localparam logic [UADDR_BITS-1:0] RESET_UADDR = 14'h0000;
   localparam logic [31:0] RESET_PC = 32'h0000_0000;
   localparam logic [4:0] PHASE_ZERO = 5'h00;

   // Decode information forwarded to both consumers.
   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [3:0] avail;
   } decode_info_t;

   // Read request toward the shared data/address bus.
   typedef struct packed {
      logic req;
      logic [31:0] addr;
   } bus_req_t;

   // Prefetch bus sequencing.
   typedef enum logic [1:0] {BUS_IDLE, BUS_ASK, BUS_READ} bus_state_t;

   // Silo storage record.
   typedef struct packed {
      logic [SILO_BYTES-1:0][7:0] bytes;
      logic [3:0] count;
   } silo_state_t;
endpackage

// ==== hdl/prefetch_silo.sv ====
/*
 * Byte silo for the prefetched instruction stream: in-order removal at
 * the head, append of a partial or whole longword at the tail, flush.
 * Assumes the writer only appends when the free room covers the write.
 */
`timescale 1ns/10ps
module prefetch_silo
   import ifetch_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic wr_en,
   input wire logic [BUS_BITS-1:0] wr_data,
   input wire logic [1:0] wr_skip,
   input wire logic [3:0] take_cnt,
   output silo_state_t state
);
   // Present and next silo record.
   silo_state_t s_reg;
   silo_state_t s_next;

   // Shift out consumed bytes, then append the new bytes behind the rest.
   always_comb
   begin
      int tk;
      int cnt;
      tk = 0;
      cnt = 0;
      s_next = s_reg;
      // Never remove more than is held.
      tk = (int'(take_cnt) > int'(s_reg.count)) ? int'(s_reg.count)
         : int'(take_cnt);
      for (int i = 0; i < SILO_BYTES; i++)
      begin
         s_next.bytes[i] = (i + tk < SILO_BYTES) ? s_reg.bytes[i + tk]
            : 8'h00; // RQ12
      end
      cnt = int'(s_reg.count) - tk;
      if (wr_en)
      begin
         // Bytes below the skip index precede the fetch point.
         for (int j = 0; j < WORD_BYTES; j++)
         begin
            if (j >= int'(wr_skip) && cnt + j - int'(wr_skip) < SILO_BYTES)
            begin
               s_next.bytes[cnt + j - int'(wr_skip)] = wr_data[8*j +: 8];
            end
         end
         cnt = cnt + WORD_BYTES - int'(wr_skip); // RQ1
      end
      s_next.count = 4'(cnt); // RQ12
      if (flush)
      begin
         s_next.count = 4'h0; // RQ11
      end
   end

   // Register the silo record.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign state = s_reg;
endmodule // prefetch_silo

// ==== hdl/instr_prefetch_microsequencer.sv ====
/*
 * Processor front end: instruction prefetch over the shared data/address
 * bus into a byte silo, decode forwarding, and the microsequencer that
 * drives micro-addresses onto the microinstruction bus and latches the
 * returned microword once per processor cycle.
 * Assumes the bus arbiter, execution unit and flow control logic share
 * clk; the microinstruction bus comes from pins and is synchronised.
 */
`timescale 1ns/10ps
module instr_prefetch_microsequencer
   import ifetch_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // Higher-precedence transfer is using the bus.
   input wire logic bus_busy,
   // Arbiter grants the pending read.
   input wire logic bus_grant,
   // Read data returned on the bus.
   input wire logic bus_rd_valid,
   input wire logic [BUS_BITS-1:0] bus_rd_data,
   // Read request toward the shared data/address bus.
   output bus_req_t shared_data_address_bus,
   // Change of instruction flow and its new address.
   input wire logic flow_change,
   input wire logic [31:0] flow_pc,
   // Stream bytes consumed by the execution unit.
   input wire logic [3:0] eu_take,
   // Partial-completion flag and its resume micro-address.
   input wire logic part_done,
   input wire logic [UADDR_BITS-1:0] resume_uaddr,
   // Microinstruction bus pin as input, output and output enable.
   input wire logic [UWORD_BITS-1:0] microinstruction_bus_in,
   output logic [UWORD_BITS-1:0] microinstruction_bus_out,
   output logic microinstruction_bus_oe,
   // Microword for the execution unit and its per-cycle strobe.
   output logic [UWORD_BITS-1:0] uinstr,
   output logic uinstr_strobe,
   // Decode information for execution unit and accelerator.
   output decode_info_t eu_decode,
   output decode_info_t fpa_decode
);
   // State of the front end apart from the silo record held in u_silo.
   typedef struct packed {
      bus_state_t bus;
      bus_req_t req;
      logic [31:0] fetch_pc;
      logic stale;
      logic [4:0] phase;
      logic [UADDR_BITS-1:0] uaddr;
      logic [UWORD_BITS-1:0] mib_out;
      logic mib_oe;
      logic [UWORD_BITS-1:0] mib_s1;
      logic [UWORD_BITS-1:0] mib_s2;
      logic [UWORD_BITS-1:0] uword;
      logic ustrobe;
      decode_info_t dec_eu;
      decode_info_t dec_fpa;
   } front_state_t;

   front_state_t r_reg;
   front_state_t r_next;

   // Silo record and its control terms.
   silo_state_t silo;
   logic silo_wr;
   logic [3:0] silo_take;
   logic dispatch_take;

   // Entry point of the microroutine for an opcode.
   function automatic logic [UADDR_BITS-1:0] entry_point(
      input logic [7:0] opcode);
      entry_point = {ENTRY_PAGE, opcode};
   endfunction

   // Bytes of a longword read that precede the fetch address.
   function automatic logic [1:0] skip_of(input logic [31:0] pc);
      skip_of = pc[1:0];
   endfunction

   // Byte storage for the prefetched stream.
   prefetch_silo u_silo (
      .clk(clk),
      .rst(rst),
      .flush(flow_change),
      .wr_en(silo_wr),
      .wr_data(bus_rd_data),
      .wr_skip(skip_of(r_reg.fetch_pc)),
      .take_cnt(silo_take),
      .state(silo)
   );

   // Next state of the prefetch, the microsequencer and the outputs.
   always_comb
   begin
      logic last_phase;
      logic [UWORD_BITS-1:0] word;
      last_phase = 1'b0;
      word = '0;
      r_next = r_reg;
      silo_wr = 1'b0;
      dispatch_take = 1'b0;

      // Two-flop synchroniser for the microinstruction bus pins.
      r_next.mib_s1 = microinstruction_bus_in;
      r_next.mib_s2 = r_reg.mib_s1;
      word = r_reg.mib_s2;

      // Prefetch: request a read when a whole longword fits.
      case (r_reg.bus)
         BUS_IDLE:
         begin
            if (!flow_change && !bus_busy
               && int'(silo.count) + WORD_BYTES <= SILO_BYTES)
            begin
               r_next.req.req = 1'b1; // RQ2
               r_next.req.addr = {r_reg.fetch_pc[31:2], 2'b00};
               r_next.stale = 1'b0;
               r_next.bus = BUS_ASK;
            end
         end
         BUS_ASK:
         begin
            // Hold the request until the arbiter grants it.
            if (bus_grant)
            begin
               r_next.req.req = 1'b0;
               r_next.bus = BUS_READ;
            end
         end
         BUS_READ:
         begin
            // Store the data unless flow changed while it was in flight.
            if (bus_rd_valid)
            begin
               silo_wr = !r_reg.stale && !flow_change; // RQ11
               if (silo_wr)
               begin
                  r_next.fetch_pc = {r_reg.fetch_pc[31:2], 2'b00}
                     + 32'(WORD_BYTES);
               end
               r_next.bus = BUS_IDLE;
            end
         end
         default:
         begin
            r_next.bus = BUS_IDLE;
         end
      endcase

      // A flow change restarts prefetch at the new address.
      if (flow_change)
      begin
         r_next.fetch_pc = flow_pc; // RQ11
         r_next.stale = r_reg.bus != BUS_IDLE;
      end

      // Processor cycle phase counter.
      last_phase = r_reg.phase == 5'(CYCLE_CLKS - 1);
      r_next.phase = last_phase ? PHASE_ZERO : r_reg.phase + 5'h01;

      // First half drives the micro-address, second half releases.
      r_next.mib_oe = r_next.phase < 5'(HALF_CLKS); // RQ7
      r_next.mib_out = UWORD_BITS'(r_reg.uaddr); // RQ7

      // End of cycle: latch the returned word and pick the next address.
      r_next.ustrobe = last_phase; // RQ9
      if (last_phase)
      begin
         r_next.uword = word; // RQ8 RQ10
         if (part_done)
         begin
            r_next.uaddr = resume_uaddr; // RQ6
         end
         else if (word[UI_DISPATCH_BIT])
         begin
            // Wait on the same address while no opcode is held.
            if (silo.count != 4'h0 && !flow_change)
            begin
               r_next.uaddr = entry_point(silo.bytes[0]); // RQ5
               dispatch_take = 1'b1;
            end
         end
         else
         begin
            r_next.uaddr = word[UI_NEXT_LSB +: UADDR_BITS]; // RQ4
         end
      end
      if (r_next.phase == PHASE_ZERO)
      begin
         r_next.mib_out = UWORD_BITS'(r_next.uaddr);
      end

      // Head of the silo forwarded as decode information.
      r_next.dec_eu.valid = silo.count != 4'h0; // RQ3
      r_next.dec_eu.opcode = silo.bytes[0];
      r_next.dec_eu.avail = silo.count;
      r_next.dec_fpa = r_next.dec_eu; // RQ3

      // Bytes removed this clock: operands plus a dispatched opcode.
      silo_take = eu_take + {3'b000, dispatch_take}; // RQ12
   end

   // Register all front end state except the silo record, which u_silo registers.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         r_reg <= '0;
         r_reg.bus <= BUS_IDLE;
         r_reg.fetch_pc <= RESET_PC;
         r_reg.uaddr <= RESET_UADDR;
         r_reg.mib_out <= UWORD_BITS'(RESET_UADDR);
         r_reg.mib_oe <= 1'b1;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // Outputs come straight from the state flops.
   assign shared_data_address_bus = r_reg.req;
   assign microinstruction_bus_out = r_reg.mib_out;
   assign microinstruction_bus_oe = r_reg.mib_oe;
   assign uinstr = r_reg.uword;
   assign uinstr_strobe = r_reg.ustrobe;
   assign eu_decode = r_reg.dec_eu;
   assign fpa_decode = r_reg.dec_fpa;
endmodule // instr_prefetch_microsequencer

// ==== test/ifetch_monitor.sv ====
/* Checker on the front end ports: bus request, microinstruction bus
   halves, microword latch and decode forwarding.
   Assumes one clock and an active-high synchronous reset. */
`timescale 1ns/10ps
module ifetch_monitor
   import ifetch_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic bus_busy,
   input wire logic bus_grant,
   input wire logic flow_change,
   input wire logic part_done,
   input wire logic [UADDR_BITS-1:0] resume_uaddr,
   input wire logic [UWORD_BITS-1:0] microinstruction_bus_in,
   input wire logic [UWORD_BITS-1:0] microinstruction_bus_out,
   input wire logic microinstruction_bus_oe,
   input wire logic [UWORD_BITS-1:0] uinstr,
   input wire logic uinstr_strobe,
   input wire bus_req_t shared_data_address_bus,
   input wire decode_info_t eu_decode,
   input wire decode_info_t fpa_decode
);
   // All checks share the clock and sleep during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Short names for the watched signals.
   wire oe = microinstruction_bus_oe;
   wire req = shared_data_address_bus.req;
   wire [13:0] ua = microinstruction_bus_out[13:0];
   wire sb = uinstr_strobe;
   a_drive_half: assert property ($rose(oe) |-> ##9 oe ##1 !oe)
      else $error("drive half length wrong");
   a_listen_half: assert property ($fell(oe) |-> ##9 !oe ##1 oe)
      else $error("listen half length wrong");
   a_cycle_period: assert property (sb |=> !sb[*8] ##12 sb)
      else $error("strobe period wrong");
   a_strobe_phase: assert property (sb |-> $rose(oe))
      else $error("strobe off cycle start");
   a_word_hold: assert property (!sb |-> $stable(uinstr))
      else $error("microword moved");
   a_word_capture: assert property (sb |->
      uinstr == $past(microinstruction_bus_in, 3))
      else $error("microword not taken from bus");
   a_addr_steady: assert property (oe && $past(oe) |-> $stable(ua))
      else $error("micro-address moved");
   a_next_seq: assert property ($rose(oe) && !$past(part_done) &&
      !uinstr[UI_DISPATCH_BIT] |-> ua == uinstr[13:0])
      else $error("next address wrong");
   a_resume_path: assert property ($rose(oe) && $past(part_done) |->
      ua == $past(resume_uaddr))
      else $error("resume address wrong");
   a_req_hold: assert property (req && !bus_grant |=> req &&
      $stable(shared_data_address_bus.addr))
      else $error("request dropped early");
   a_req_drop: assert property (req && bus_grant |=> !req)
      else $error("request kept after grant");
   a_req_free: assert property ($rose(req) |->
      !$past(bus_busy) && !$past(flow_change))
      else $error("request while bus busy");
   a_silo_bound: assert property (eu_decode.avail <= 4'h8)
      else $error("silo over eight");
   a_decode_twin: assert property (eu_decode == fpa_decode)
      else $error("decode copies differ");
   // Main scenarios reached.
   c_dispatch: cover property (sb && uinstr[UI_DISPATCH_BIT]);
   c_grant: cover property (req && bus_grant);
   c_resume: cover property ($rose(oe) && $past(part_done));
endmodule // ifetch_monitor

// ==== test/cs_model.sv ====
/* Control store stand-in: takes the micro-address in the first half of
   each cycle and answers with a 40-bit word in the second half.
   Assumes the address sits in the low bits while the enable is high. */
`timescale 1ns/10ps
module cs_model
   import ifetch_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic disp_en,
   input wire logic oe,
   input wire logic [UWORD_BITS-1:0] addr_bus,
   output logic [UWORD_BITS-1:0] word
);
   logic [UADDR_BITS-1:0] addr_reg;
   logic dsp_reg;
   logic [3:0] lag_reg;
   // Next address is one on; some addresses ask for a dispatch.
   function automatic logic [UWORD_BITS-1:0] rom(input logic [13:0] a);
      return {a, 11'h000, dsp_reg && a[2:0] == 3'h5, a + 14'h0001};
   endfunction
   // Undriven pin toggles each clock so stale data never matches.
   always_ff @(posedge clk)
      if (rst)
      begin
         word <= 40'ha5_a5a5_a5a5;
         lag_reg <= 4'h0;
      end
      else
      begin
         if (oe)
         begin
            addr_reg <= addr_bus[UADDR_BITS-1:0];
            dsp_reg <= disp_en;
         end
         lag_reg <= oe ? 4'h0 : lag_reg + {3'h0, lag_reg != 4'hf};
         if (oe || (slow && lag_reg < 4'h2))
            word <= ~word;
         else
            word <= rom(addr_reg);
      end
endmodule // cs_model

// ==== test/tb.sv ====
/* Self-checking bench: bus and memory, flow changes, stream use,
   dispatch and resume.
   Assumes the control store model and the checker beside it. */
`timescale 1ns/10ps
`define CHECK(act, exp) begin check_count++; \
   if ((act) !== (exp)) begin miscompares++; \
   $display("wrong value at %0t: %h expected %h", $time, act, exp); \
   end end
module tb
   import ifetch_pkg::*;
   ;
   logic clk = 0, rst = 1, bus_busy = 0, bus_grant = 0, bus_rd_valid = 0;
   logic flow_change = 0, part_done = 0, slow = 0, disp_en = 0;
   logic busy_en = 0;
   logic [31:0] bus_rd_data = '0, flow_pc = '0, pc = '0, rd_addr;
   logic [3:0] eu_take = '0;
   logic [13:0] resume_uaddr = '0, e_w;
   logic [1:0] look = '0;
   logic [UWORD_BITS-1:0] mib_in, mib_out, uinstr;
   logic mib_oe, uinstr_strobe;
   bus_req_t sdab;
   decode_info_t eu_decode, fpa_decode;
   logic [13:0] exp_q[$];
   int miscompares = 0, check_count = 0;
   // Memory contents by byte address.
   function automatic logic [7:0] f(input logic [31:0] p);
      return p[7:0] ^ p[15:8] ^ 8'h3c;
   endfunction
   always #5 clk = ~clk;
   instr_prefetch_microsequencer instr_prefetch_microsequencer_inst (
      .clk, .rst, .bus_busy, .bus_grant, .bus_rd_valid, .bus_rd_data,
      .shared_data_address_bus(sdab), .flow_change, .flow_pc, .eu_take,
      .part_done, .resume_uaddr, .microinstruction_bus_in(mib_in),
      .microinstruction_bus_out(mib_out), .microinstruction_bus_oe(mib_oe),
      .uinstr, .uinstr_strobe, .eu_decode, .fpa_decode);
   cs_model cs_model_inst (.clk, .rst, .slow, .disp_en, .oe(mib_oe),
      .addr_bus(mib_out), .word(mib_in));
   // Other bus traffic of higher precedence.
   always @(posedge clk) #1 bus_busy = busy_en & ($urandom_range(3) == 0);
   // Arbiter and memory: grant a read, answer a few clocks later.
   initial forever
   begin
      @(posedge clk) #1;
      if (sdab.req === 1'b1)
      begin
         rd_addr = sdab.addr;
         bus_grant = 1;
         @(posedge clk) #1 bus_grant = 0;
         repeat ($urandom_range(4)) @(posedge clk) #1;
         bus_rd_valid = 1;
         bus_rd_data = {f(rd_addr + 3), f(rd_addr + 2), f(rd_addr + 1),
            f(rd_addr)};
         @(posedge clk) #1 bus_rd_valid = 0;
         bus_rd_data = ~bus_rd_data;
      end
   end
   // Wait until n stream bytes are offered.
   task automatic wait_bytes(input int n);
      for (int k = 0; k < 300 && !(eu_decode.valid === 1'b1 &&
         eu_decode.avail >= n); k++)
         @(posedge clk) #1;
      // A stream that never arrives counts as a mismatch.
      if (!(eu_decode.valid === 1'b1 && eu_decode.avail >= n))
         miscompares++;
   endtask
   // Queue an expected value for the watcher.
   task automatic note(input logic [13:0] e, input logic [1:0] kind);
      exp_q.push_back(e);
      look = kind;
      @(posedge clk) #1 look = 0;
   endtask
   // Redirect the stream and expect the new first byte.
   task automatic jump(input logic [31:0] p);
      flow_change = 1;
      flow_pc = p;
      @(posedge clk) #1 flow_change = 0;
      pc = p;
      @(posedge clk) #1;
      wait_bytes(1);
      note({6'h00, f(pc)}, 2'd1);
   endtask
   // Consume n bytes and expect the byte after them at the head.
   task automatic take(input int n);
      wait_bytes(n);
      eu_take = 4'(n);
      @(posedge clk) #1 eu_take = 0;
      pc = pc + n;
      @(posedge clk) #1;
      wait_bytes(1);
      note({6'h00, f(pc)}, 2'd1);
   endtask
   // Compare each noted value once the outputs have settled.
   always @(negedge clk)
      if (look != 2'd0)
      begin
         e_w = exp_q.pop_front();
         if (look == 2'd1)
         begin
            `CHECK({6'h00, eu_decode.opcode}, e_w)
            `CHECK(fpa_decode, eu_decode)
         end
         else
            `CHECK(mib_out[13:0], e_w)
      end
   // Main sequence.
   initial
   begin
      void'($urandom(32'h4a5a));
      repeat (16) @(posedge clk);
      #1 rst = 0;
      jump(32'h0000_0100);
      repeat (150) @(posedge clk) #1;
      `CHECK(eu_decode.avail, 4'h8)
      `CHECK(sdab.req, 1'b0)
      busy_en = 1;
      for (int i = 0; i < 60; i++)
      begin
         slow = i[0];
         if (i % 12 == 11)
            jump($urandom);
         take($urandom_range(1, 3));
      end
      busy_en = 0;
      jump(32'h0000_0200);
      disp_en = 1;
      for (int i = 0; i < 40; i++)
      begin
         for (int k = 0; k < 25 && uinstr_strobe !== 1'b1; k++)
            @(posedge clk) #1;
         // A missing cycle strobe counts as a mismatch.
         if (uinstr_strobe !== 1'b1)
            miscompares++;
         if (uinstr[UI_DISPATCH_BIT] === 1'b1 && eu_decode.valid === 1'b1)
         begin
            note({6'h00, f(pc)}, 2'd2);
            pc = pc + 1;
         end
         else
            @(posedge clk) #1;
      end
      disp_en = 0;
      for (int i = 0; i < 4; i++)
      begin
         resume_uaddr = 14'($urandom);
         part_done = 1;
         repeat (25) @(posedge clk) #1;
         part_done = 0;
         repeat (30) @(posedge clk) #1;
      end
      end_of_test;
   end
   // Cut a hung run short.
   initial
   begin
      #400000;
      miscompares++;
      end_of_test;
   end
   // Print the counts and the verdict, then stop.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
endmodule // tb
bind instr_prefetch_microsequencer ifetch_monitor ifetch_monitor_inst (
   .clk, .rst, .bus_busy, .bus_grant, .flow_change, .part_done,
   .resume_uaddr, .microinstruction_bus_in, .microinstruction_bus_out,
   .microinstruction_bus_oe, .uinstr, .uinstr_strobe,
   .shared_data_address_bus, .eu_decode, .fpa_decode);
